// file: src/hprk_consts.vh
/*
 * Constants for the keypad-driven host power and reset controller.
 * Assumes a 100 MHz system clock; times are given in ms and converted here.
 */
`ifndef HPRK_CONSTS_VH
`define HPRK_CONSTS_VH

`define HPRK_CLK_MHZ 100
`define HPRK_ON_HOLD_MS 250
`define HPRK_LONG_HOLD_MS 4000
`define HPRK_EXTEND_MS 5000
`define HPRK_RESET_MS 1000
`define HPRK_PULSE_MS_DEFAULT 1000
// Cycles per millisecond tick
`define HPRK_MS_CYCLES (`HPRK_CLK_MHZ * 1000)
`define HPRK_CNT_W 17
`define HPRK_MS_W 13

`endif

// file: src/hprk_ctrl.v
/*
 * Host power and reset keypad controller: times key holds, pulses the
 * power-switch and reset pins, requests display blank and self reset.
 * Assumes keys are already debounced active-high levels from the keypad
 * scanner; the sense input and keys come from pins and are synchronised.
 */
`timescale 1ns/1ns
`default_nettype none
`include "hprk_consts.vh"

module hprk_ctrl #(
    parameter [`HPRK_CNT_W-1:0] MS_CYCLES = `HPRK_MS_CYCLES
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Pins and keys
    input wire power_sense,
    input wire key_confirm,
    input wire key_cancel,
    input wire watchdog_reset_req,
    // Configuration
    input wire en_power_on,
    input wire en_hard_off,
    input wire en_hard_reset,
    input wire en_blank,
    input wire power_invert,
    input wire reset_invert,
    input wire [`HPRK_MS_W-1:0] pulse_ms,
    // Power-switch pin
    output reg pwr_sw_out,
    output reg pwr_sw_oe,
    // Reset pin
    output reg host_rst_out,
    output reg host_rst_oe,
    // Status
    output reg display_blank,
    output reg self_reset_req
);

    // One-hot sequencer states; only one action runs at a time
    localparam [5:0] ST_IDLE = 6'b00_0001;
    localparam [5:0] ST_HOLD_ON = 6'b00_0010;
    localparam [5:0] ST_HOLD_OFF = 6'b00_0100;
    localparam [5:0] ST_HOLD_RST = 6'b00_1000;
    localparam [5:0] ST_PWR = 6'b01_0000;
    localparam [5:0] ST_RST = 6'b10_0000;

    // Reset release through two flops
    // Asserts at once, releases on an edge so no flop leaves reset alone
    reg [1:0] rst_sync;
    wire srst_n = rst_sync[1];
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end

    // Pin inputs through two flops each; only stage 2 is read
    reg [3:0] in_s1;
    reg [3:0] in_s2;
    always @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            in_s1 <= 4'h0;
            in_s2 <= 4'h0;
        end else begin
            in_s1 <= {watchdog_reset_req, key_cancel, key_confirm, power_sense};
            in_s2 <= in_s1;
        end
    end
    wire sense = in_s2[0];
    wire confirm = in_s2[1];
    wire cancel = in_s2[2];
    wire wdog = in_s2[3];

    // Millisecond tick prescaler
    // Free-running, so the first ms of any span may be short by under one ms
    reg [`HPRK_CNT_W-1:0] pre;
    wire tick = (pre == MS_CYCLES - 1'b1);
    always @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            pre <= {`HPRK_CNT_W{1'b0}};
        end else if (tick) begin
            pre <= {`HPRK_CNT_W{1'b0}};
        end else begin
            pre <= pre + 1'b1;
        end
    end

    // Sequencer state; ms counts ticks since the current phase began
    reg [5:0] state;
    reg [`HPRK_MS_W-1:0] ms;
    reg extending;
    reg ext_phase;
    reg from_key;
    reg [5:0] next_state;
    reg [`HPRK_MS_W-1:0] next_ms;
    reg next_extending;
    reg next_ext_phase;
    reg next_from_key;
    reg next_self_reset;

    // Elapsed ms including the current tick
    wire [`HPRK_MS_W-1:0] ms_inc = ms + {{(`HPRK_MS_W-1){1'b0}}, tick};

    // Sequencing; watchdog reset wins over key holds only in idle; a hold or pulse in progress ignores it
    always @* begin
        next_state = state;
        next_ms = ms_inc;
        next_extending = extending;
        next_ext_phase = ext_phase;
        next_from_key = from_key;
        next_self_reset = 1'b0;
        case (state)
            ST_IDLE: begin
                // Priority: watchdog, power-on, hard reset, hard off
                next_ms = {`HPRK_MS_W{1'b0}};
                if (wdog) begin
                    next_state = ST_RST;
                    next_from_key = 1'b0;
                end else if (confirm && !sense && en_power_on) begin
                    next_state = ST_HOLD_ON;
                end else if (confirm && sense && en_hard_reset) begin
                    next_state = ST_HOLD_RST;
                end else if (cancel && sense && en_hard_off) begin
                    next_state = ST_HOLD_OFF;
                end
            end
            ST_HOLD_ON: begin
                // Release, sense change or disable drops the hold silently
                if (!confirm || sense || !en_power_on) begin
                    next_state = ST_IDLE;
                end else if (ms_inc >= `HPRK_ON_HOLD_MS) begin
                    next_state = ST_PWR;
                    next_ms = {`HPRK_MS_W{1'b0}};
                    next_extending = 1'b0;
                    next_ext_phase = 1'b0;
                end
            end
            ST_HOLD_OFF: begin
                // Cancel must stay down the whole four seconds
                if (!cancel || !sense || !en_hard_off) begin
                    next_state = ST_IDLE;
                end else if (ms_inc >= `HPRK_LONG_HOLD_MS) begin
                    next_state = ST_PWR;
                    next_ms = {`HPRK_MS_W{1'b0}};
                    next_extending = 1'b1;
                    next_ext_phase = 1'b0;
                end
            end
            ST_HOLD_RST: begin
                // Same confirm key as power-on, told apart by sense
                if (!confirm || !sense || !en_hard_reset) begin
                    next_state = ST_IDLE;
                end else if (ms_inc >= `HPRK_LONG_HOLD_MS) begin
                    next_state = ST_RST;
                    next_ms = {`HPRK_MS_W{1'b0}};
                    next_from_key = 1'b1;
                end
            end
            ST_PWR: begin
                // Minimum width first, then an extension with its own count,
                // so a long pulse_ms cannot wrap the ms counter
                if (ext_phase) begin
                    if (!cancel || ms_inc >= `HPRK_EXTEND_MS) begin
                        next_state = ST_IDLE;
                    end
                end else if (ms_inc >= pulse_ms) begin
                    if (extending && cancel) begin
                        next_ext_phase = 1'b1;
                        next_ms = {`HPRK_MS_W{1'b0}};
                    end else begin
                        next_state = ST_IDLE;
                    end
                end
            end
            ST_RST: begin
                // Fixed one-second pulse; watchdog resets share this state
                if (ms_inc >= `HPRK_RESET_MS) begin
                    next_state = ST_IDLE;
                    next_self_reset = from_key;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // State and pin drivers; idle pins float with output value zero
    always @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            state <= ST_IDLE;
            ms <= {`HPRK_MS_W{1'b0}};
            extending <= 1'b0;
            ext_phase <= 1'b0;
            from_key <= 1'b0;
            pwr_sw_out <= 1'b0;
            pwr_sw_oe <= 1'b0;
            host_rst_out <= 1'b0;
            host_rst_oe <= 1'b0;
            display_blank <= 1'b0;
            self_reset_req <= 1'b0;
        end else begin
            state <= next_state;
            ms <= next_ms;
            extending <= next_extending;
            ext_phase <= next_ext_phase;
            from_key <= next_from_key;
            pwr_sw_oe <= (next_state == ST_PWR);
            pwr_sw_out <= (next_state == ST_PWR) & power_invert;
            host_rst_oe <= (next_state == ST_RST);
            host_rst_out <= (next_state == ST_RST) & reset_invert;
            // Only the display is blanked; fan logic sees nothing
            display_blank <= en_blank & ~sense;
            self_reset_req <= next_self_reset;
        end
    end

endmodule
`default_nettype wire

// file: tb/hprk_ctrl_checker.sv
/* Port checker for hprk_ctrl.
   Assumes the bind below reaches every instance. */
`timescale 1ns/1ns
`default_nettype none
module hprk_ctrl_checker (
    // Inputs
    input wire logic clk,
    input wire logic rst_n,
    input wire logic power_sense,
    input wire logic key_confirm,
    input wire logic key_cancel,
    input wire logic watchdog_reset_req,
    input wire logic en_power_on,
    input wire logic en_hard_off,
    input wire logic en_hard_reset,
    input wire logic en_blank,
    input wire logic power_invert,
    input wire logic reset_invert,
    // Outputs
    input wire logic pwr_sw_out,
    input wire logic pwr_sw_oe,
    input wire logic host_rst_out,
    input wire logic host_rst_oe,
    input wire logic display_blank,
    input wire logic self_reset_req
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_PWR_LEVEL:
    assert property (pwr_sw_oe |-> pwr_sw_out == power_invert) else $error("power level");
    AST_PWR_FLOAT:
    assert property (!pwr_sw_oe |-> !pwr_sw_out) else $error("power float");
    AST_RST_LEVEL:
    assert property (host_rst_oe |-> host_rst_out == reset_invert) else $error("reset level");
    AST_RST_FLOAT:
    assert property (!host_rst_oe |-> !host_rst_out) else $error("reset float");
    AST_PWR_CAUSE:
    assert property ($rose(pwr_sw_oe) |-> $past(key_confirm && en_power_on
        || key_cancel && en_hard_off, 4)) else $error("power pulse cause");
    AST_BLANK_ON:
    assert property ((en_blank && !power_sense)[*8] |-> display_blank) else $error("blank on");
    AST_BLANK_OFF:
    assert property (power_sense[*8] |-> !display_blank) else $error("blank off");
    AST_SELF_ONE:
    assert property (self_reset_req |=> !self_reset_req) else $error("self reset width");
    AST_SELF_AFTER:
    assert property (self_reset_req |-> $fell(host_rst_oe)) else $error("self reset timing");
    AST_RST_CAUSE:
    assert property ($rose(host_rst_oe) |-> ($past(watchdog_reset_req, 3)
        || $past(key_confirm && en_hard_reset, 3))) else $error("reset pulse cause");
    AST_ONE_ACTION:
    assert property (!(pwr_sw_oe && host_rst_oe)) else $error("both pins driven");
endmodule
bind hprk_ctrl hprk_ctrl_checker hprk_ctrl_checker_i (.clk, .rst_n, .power_sense,
    .key_confirm, .key_cancel, .watchdog_reset_req, .en_power_on, .en_hard_off,
    .en_hard_reset, .en_blank, .power_invert,
    .reset_invert, .pwr_sw_out, .pwr_sw_oe, .host_rst_out, .host_rst_oe, .display_blank,
    .self_reset_req);
`default_nettype wire

// file: tb/hprk_board.sv
/* Motherboard model: pulled-up switch pins, host power toggled by a press.
   Assumes enables are high while the controller drives. */
`timescale 1ns/1ns
`default_nettype none
module hprk_board (
    // Controller pins
    input wire logic pwr_out,
    input wire logic pwr_oe,
    input wire logic rst_out,
    input wire logic rst_oe,
    // Board side
    output logic pwr_pin,
    output logic rst_pin,
    output logic sense
);
    logic armed = 1'h0;
    // Pull-ups when released; pins left in default drive mode
    assign pwr_pin = pwr_oe ? pwr_out : 1'h1;
    assign rst_pin = rst_oe ? rst_out : 1'h1;
    // Power flips after a real press, not on the reset edge
    initial sense = 1'h0;
    always @(posedge pwr_oe) armed <= 1'h1;
    always @(negedge pwr_oe) if (armed) sense <= ~sense;
endmodule
`default_nettype wire

// file: tb/host_power_reset_keypad_control_bench.sv
/* Bench for hprk_ctrl and board model.
   Assumes MS_CYCLES of 4, so one ms tick is 4 cycles. */
`timescale 1ns/1ns
`default_nettype none
module host_power_reset_keypad_control_bench;
    localparam int TICK = 4;
    logic clk = 1'h0, rst_n = 1'h0, key = 1'h0, kc = 1'h0, wd = 1'h0, en_on = 1'h1;
    logic eb = 1'h1, ip = 1'h0, ir = 1'h0;
    logic [12:0] pms = 13'h0010;
    logic po, poe, ro, roe, blank, srq, ppin, rpin, sense;
    int bad_count = 0, samples_checked = 0, w = 0, nself = 0;
    // Clock and self reset pulse count
    always #5 clk = ~clk;
    always @(negedge clk) if (srq === 1'h1) nself++;
    hprk_ctrl #(.MS_CYCLES(17'h0_0004)) hprk_ctrl_i (.clk(clk), .rst_n(rst_n),
        .power_sense(sense), .key_confirm(key), .key_cancel(kc), .watchdog_reset_req(wd),
        .en_power_on(en_on), .en_hard_off(1'h1), .en_hard_reset(1'h1), .en_blank(eb),
        .power_invert(ip), .reset_invert(ir), .pulse_ms(pms), .pwr_sw_out(po),
        .pwr_sw_oe(poe), .host_rst_out(ro), .host_rst_oe(roe), .display_blank(blank),
        .self_reset_req(srq));
    hprk_board hprk_board_i (.pwr_out(po), .pwr_oe(poe), .rst_out(ro), .rst_oe(roe),
        .pwr_pin(ppin), .rst_pin(rpin), .sense(sense));
    task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %0d seen %0d", n, e, g);
        end
    endtask
    // Prescaler phase and input sync allow a few ticks either way
    task automatic check_near(input string n, input int e, input int g);
        check(n, e, (g > e - 12 && g < e + 12) ? e : g);
    endtask
    // Cycles that a span of ms ticks lasts
    function automatic int exp_cycles(input int ms);
        return ms * TICK;
    endfunction
    // Hold the cancel key (cx set) or the confirm key for c cycles
    task automatic hold(input bit cx, input int c);
        if (cx) kc = 1'h1;
        else key = 1'h1;
        repeat (c) @(negedge clk);
        kc = 1'h0;
        key = 1'h0;
    endtask
    // Width of next enable pulse, 0 if none within lim
    task automatic pulse_of(input bit r, input int lim);
        w = 0;
        while ((r ? roe : poe) !== 1'h1 && lim > 0) begin
            @(negedge clk);
            lim--;
        end
        if (lim > 0) check("pin level", r ? ir : ip, r ? rpin : ppin);
        while ((r ? roe : poe) === 1'h1) begin
            @(negedge clk);
            w++;
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Main sequence
    initial begin
        void'($urandom(99));
        ip = 1'($urandom);
        ir = 1'($urandom);
        pms = 13'(5 + $urandom % 16);
        repeat (8) @(negedge clk);
        rst_n = 1'h1;
        repeat (10) @(negedge clk);
        check("blank", 1, blank);
        fork
            hold(0, 960);
            pulse_of(0, 1020);
        join
        check("early release", 0, w);
        en_on = 1'h0;
        fork
            hold(0, 1080);
            pulse_of(0, 1100);
        join
        check("disabled", 0, w);
        en_on = 1'h1;
        eb = 1'h0;
        repeat (5) @(negedge clk);
        check("blank disabled", 0, blank);
        eb = 1'h1;
        fork
            hold(0, 1040);
            pulse_of(0, 1100);
        join
        check_near("power pulse", exp_cycles(pms), w);
        repeat (10) @(negedge clk);
        check("unblank", 0, blank);
        wd = 1'h1;
        @(negedge clk);
        wd = 1'h0;
        pulse_of(1, 20);
        check_near("watchdog", exp_cycles(1000), w);
        repeat (3) @(negedge clk);
        check("no self reset", 0, nself);
        fork
            hold(0, 16400);
            pulse_of(1, 16400);
        join
        check_near("reset pulse", exp_cycles(1000), w);
        repeat (3) @(negedge clk);
        check("self reset", 1, nself);
        fork
            hold(1, exp_cycles(4000) + 800);
            pulse_of(0, 16100);
        join
        check_near("hard off release", 800, w);
        repeat (10) @(negedge clk);
        check("blank after off", 1, blank);
        pms = 13'(5 + $urandom % 16);
        fork
            hold(0, 1040);
            pulse_of(0, 1100);
        join
        check_near("power pulse again", exp_cycles(pms), w);
        fork
            hold(1, exp_cycles(4000 + pms + 5000) + 400);
            pulse_of(0, 16100);
        join
        check_near("hard off limit", exp_cycles(pms + 5000), w);
        close_out();
    end
    // Hang guard
    initial begin
        #950000;
        bad_count++;
        close_out();
    end
endmodule
`default_nettype wire
